/* File: src/uart_hostport_pkg.sv */
/*
  package for the quad uart host strobe port and interrupt output control:
  register indices, field positions, reset values, apb map and carrier types.
  assumes one 100 mhz system clock and a synchronous active-low reset.
*/
package uart_hostport_pkg;

  localparam int unsigned NUM_CHAN  = 4;
  localparam int unsigned ADDR_BITS = 3;
  localparam int unsigned DATA_BITS = 8;

  // per-channel register indices on the strobe port (low three address lines)
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_IER  = 3'h1;
  localparam logic [2:0] IDX_ISR  = 3'h2;
  localparam logic [2:0] IDX_LCR  = 3'h3;
  localparam logic [2:0] IDX_MCR  = 3'h4;
  localparam logic [2:0] IDX_SPR  = 3'h7;

  // irq_enable_reg field positions
  localparam int unsigned IER_RX_DATA_BIT   = 0;
  localparam int unsigned IER_TX_EMPTY_BIT  = 1;
  localparam int unsigned IER_RX_ERR_BIT    = 2;
  localparam int unsigned IER_MODEM_BIT     = 3;
  localparam logic [7:0]  IER_USED_MASK     = 8'h0F;

  // modem_control_reg three-state interrupt enable
  localparam int unsigned MCR_IRQ_OE_BIT = 3;

  // source identification codes read back at IDX_ISR
  localparam logic [7:0] ISR_NONE     = 8'h01;
  localparam logic [7:0] ISR_RX_ERR   = 8'h06;
  localparam logic [7:0] ISR_RX_DATA  = 8'h04;
  localparam logic [7:0] ISR_TX_EMPTY = 8'h02;
  localparam logic [7:0] ISR_MODEM    = 8'h00;

  // values after reset
  localparam logic [7:0] IER_RESET = 8'h00;
  localparam logic [7:0] LCR_RESET = 8'h00;
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [7:0] SPR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // apb map: channel registers at byte (chan*8 + idx)*4, then a status word
  localparam logic [7:0] APB_CHAN_STRIDE = 8'h20;
  localparam logic [7:0] APB_STATUS_ADDR = 8'h80;
  localparam int unsigned APB_ADDR_BITS  = 8;

  typedef struct packed {
    logic modem_chg;
    logic rx_err;
    logic tx_empty;
    logic rx_data;
  } irq_cond_type;

  typedef struct packed {
    logic [3:0] cs_n;
    logic [2:0] addr;
    logic       rd_n;
    logic       wr_n;
  } host_ctl_type;

endpackage : uart_hostport_pkg

/* File: src/chan_irq_gate.sv */
/*
  one channel's interrupt output stage: condition gating by the enable
  register, and drive / three-state decision for the channel pin.
  assumes condition inputs synchronous to sys_clk_in.
*/
module chan_irq_gate (
  input  wire logic                           sys_clk_in,
  input  wire logic                           nrst_in,
  input  wire uart_hostport_pkg::irq_cond_type cond_in,
  input  wire logic [7:0]                     ier_in,
  input  wire logic                           mcr_oe_in,
  input  wire logic                           drive_select_in,
  input  wire logic                           combined_mode_in,
  output logic                                pending_out,
  output logic                                irq_out,
  output logic                                irq_oe_out
);

  logic pending_next;
  logic drive_next;

  always_comb begin
    pending_next = (cond_in.rx_data   & ier_in[uart_hostport_pkg::IER_RX_DATA_BIT])  |
                   (cond_in.tx_empty  & ier_in[uart_hostport_pkg::IER_TX_EMPTY_BIT]) |
                   (cond_in.rx_err    & ier_in[uart_hostport_pkg::IER_RX_ERR_BIT])   |
                   (cond_in.modem_chg & ier_in[uart_hostport_pkg::IER_MODEM_BIT]);
    // select pin overrides the bit; bit decides otherwise
    drive_next = drive_select_in | mcr_oe_in;
    // pins take other duties in combined mode, so never drive them here
    if (combined_mode_in) begin
      drive_next = 1'b0;
    end
  end

  // left combinational so the shared request lags its cause by one edge only
  assign pending_out = pending_next;

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      irq_out     <= 1'b0;
      irq_oe_out  <= 1'b0;
    end else begin
      irq_out     <= pending_next & drive_next;
      irq_oe_out  <= drive_next;
    end
  end

endmodule : chan_irq_gate

/* File: src/quad_uart_host_strobe_irq_ctrl.sv */
/*
  quad uart host strobe port and interrupt output control: per-channel
  registers reached by split read/write strobes and by an apb slave,
  per-channel three-state interrupt pins and a shared open-drain request.
  assumes strobe, address and select pins already synchronous to sys_clk_in.
*/
// The implementer's own choices: the address map and the APB interface to the registers.
// Function
// - interrupt when an enabled rx error, rx data, tx empty or modem change exists
// - select pin high: all channel interrupt pins driven whatever bit 3 holds
// - select pin low: modem control bit 3 decides driven or high impedance
// - host sets modem control bit 3 to 1; device then drives that pin
// - read strobe falling edge puts addressed register on the data bus
// - write strobe falling edge stores data bus into addressed register
// - combined mode ignores read strobe, write strobe and select pin
// - combined mode gives channel interrupt pins up to other duties
// - channel pin high only with bit 3 set or select pin high, condition enabled and present
// - host selects a channel by its low chip select; only it responds
// - combined mode merges channel interrupts onto one low shared request
module quad_uart_host_strobe_irq_ctrl #(
  parameter int unsigned NCH = uart_hostport_pkg::NUM_CHAN
) (
  input  wire logic                            sys_clk_in,
  input  wire logic                            nrst_in,
  input  wire uart_hostport_pkg::host_ctl_type host_ctl_in,
  input  wire logic [7:0]                      host_data_in,
  output logic [7:0]                           host_data_out,
  output logic                                 host_data_oe_out,
  input  wire logic                            irq_drive_select_in,
  input  wire logic                            combined_mode_in,
  input  wire uart_hostport_pkg::irq_cond_type [NCH-1:0] irq_cond_in,
  output logic [NCH-1:0]                       irq_out,
  output logic [NCH-1:0]                       irq_oe_out,
  output logic                                 irq_shared_n_out,
  output logic                                 irq_shared_n_oe_out,
  input  wire logic [7:0]                      paddr,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [31:0]                     pwdata,
  output logic [31:0]                          prdata,
  output logic                                 pready,
  output logic                                 pslverr
);

  logic [7:0]     ier_reg  [NCH];
  logic [7:0]     lcr_reg  [NCH];
  logic [7:0]     mcr_reg  [NCH];
  logic [7:0]     spr_reg  [NCH];
  logic [7:0]     data_reg [NCH];
  logic [NCH-1:0] pending;
  logic           rd_prev_reg;
  logic           wr_prev_reg;
  logic           rd_fall;
  logic           wr_fall;
  logic           rd_active;
  logic [NCH-1:0] cs_sel;
  logic           any_sel;
  logic [1:0]     first_ch;
  logic           apb_setup;
  logic           apb_access;
  logic           apb_wr;
  logic [1:0]     apb_ch;
  logic [2:0]     apb_idx;
  logic           apb_is_chan;
  logic           apb_is_status;
  logic           pslverr_reg;
  logic           sel_eff;

  // lowest selected channel answers a read if more than one select is low
  function automatic logic [1:0] lowest_sel(input logic [NCH-1:0] sel);
    logic [1:0] ch;
    ch = 2'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (sel[i]) begin
        ch = 2'(i);
      end
    end
    return ch;
  endfunction : lowest_sel

  function automatic logic [7:0] isr_code(input uart_hostport_pkg::irq_cond_type c,
                                          input logic [7:0] irq_enable_reg);
    logic [7:0] code;
    code = uart_hostport_pkg::ISR_NONE;
    if (c.rx_err & irq_enable_reg[uart_hostport_pkg::IER_RX_ERR_BIT]) begin
      code = uart_hostport_pkg::ISR_RX_ERR;
    end else if (c.rx_data & irq_enable_reg[uart_hostport_pkg::IER_RX_DATA_BIT]) begin
      code = uart_hostport_pkg::ISR_RX_DATA;
    end else if (c.tx_empty & irq_enable_reg[uart_hostport_pkg::IER_TX_EMPTY_BIT]) begin
      code = uart_hostport_pkg::ISR_TX_EMPTY;
    end else if (c.modem_chg & irq_enable_reg[uart_hostport_pkg::IER_MODEM_BIT]) begin
      code = uart_hostport_pkg::ISR_MODEM;
    end
    return code;
  endfunction : isr_code

  // shared by strobe and apb reads
  function automatic logic [7:0] read_reg(input logic [1:0] ch, input logic [2:0] idx);
    logic [7:0] val;
    val = 8'h00;
    case (idx)
      uart_hostport_pkg::IDX_DATA: val = data_reg[ch];
      uart_hostport_pkg::IDX_IER:  val = ier_reg[ch];
      uart_hostport_pkg::IDX_ISR:  val = isr_code(irq_cond_in[ch], ier_reg[ch]);
      uart_hostport_pkg::IDX_LCR:  val = lcr_reg[ch];
      uart_hostport_pkg::IDX_MCR:  val = mcr_reg[ch];
      uart_hostport_pkg::IDX_SPR:  val = spr_reg[ch];
      default:                     val = 8'h00;
    endcase
    return val;
  endfunction : read_reg

  // status: bit 12 shared request pulled, 11:8 pins driven, 7:4 pending, 0 select
  function automatic logic [31:0] status_word();
    logic [31:0] w;
    w       = 32'h0000_0000;
    w[12]   = irq_shared_n_oe_out;
    w[11:8] = irq_oe_out;
    w[7:4]  = pending;
    w[0]    = sel_eff;
    return w;
  endfunction : status_word

  // strobe edge detection
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      rd_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
    end else begin
      rd_prev_reg <= host_ctl_in.rd_n;
      wr_prev_reg <= host_ctl_in.wr_n;
    end
  end

  assign cs_sel    = ~host_ctl_in.cs_n;
  assign any_sel   = |cs_sel;
  assign first_ch  = lowest_sel(cs_sel);
  // combined-mode strobe access is not part of this port
  assign rd_fall   = rd_prev_reg & ~host_ctl_in.rd_n & any_sel & ~combined_mode_in;
  assign wr_fall   = wr_prev_reg & ~host_ctl_in.wr_n & any_sel & ~combined_mode_in;
  assign rd_active = ~host_ctl_in.rd_n & any_sel & ~combined_mode_in;

  // read data captured once at the falling edge, held while the strobe stays low
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      host_data_out    <= 8'h00;
      host_data_oe_out <= 1'b0;
    end else begin
      if (rd_fall) begin
        host_data_out <= read_reg(first_ch, host_ctl_in.addr);
      end
      host_data_oe_out <= rd_active;
    end
  end

  // apb decode
  assign apb_setup     = psel & ~penable;
  assign apb_access    = psel & penable;
  assign apb_ch        = paddr[6:5];
  assign apb_idx       = paddr[4:2];
  assign apb_is_chan   = (paddr < uart_hostport_pkg::APB_STATUS_ADDR) && (paddr[1:0] == 2'h0);
  assign apb_is_status = (paddr == uart_hostport_pkg::APB_STATUS_ADDR);
  assign apb_wr        = apb_access & pwrite & apb_is_chan;
  assign pready        = 1'b1;
  assign pslverr       = apb_access & pslverr_reg;

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      prdata      <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      pslverr_reg <= ~(apb_is_chan | apb_is_status);
      prdata      <= 32'h0000_0000;
      if (!pwrite && apb_is_chan) begin
        prdata <= {24'h00_0000, read_reg(apb_ch, apb_idx)};
      end else if (!pwrite && apb_is_status) begin
        prdata <= status_word();
      end
    end
  end

  // write select per register; the strobe beats apb on a same-cycle clash
  function automatic logic wr_hit(input int c, input logic [2:0] idx);
    return (wr_fall && cs_sel[c] && host_ctl_in.addr == idx) ||
           (apb_wr && apb_ch == 2'(c) && apb_idx == idx);
  endfunction : wr_hit

  // only byte lane 0 of pwdata reaches the registers
  function automatic logic [7:0] wr_value(input int c, input logic [2:0] idx);
    logic [7:0] val;
    val = pwdata[7:0];
    if (wr_fall && cs_sel[c] && host_ctl_in.addr == idx) begin
      val = host_data_in;
    end
    return val;
  endfunction : wr_value

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      for (int c = 0; c < NCH; c++) begin
        data_reg[c] <= uart_hostport_pkg::DATA_RESET;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_hit(c, uart_hostport_pkg::IDX_DATA)) begin
          data_reg[c] <= wr_value(c, uart_hostport_pkg::IDX_DATA);
        end
      end
    end
  end

  // only the four enable bits are kept; upper bits read 0
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      for (int c = 0; c < NCH; c++) begin
        ier_reg[c] <= uart_hostport_pkg::IER_RESET;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_hit(c, uart_hostport_pkg::IDX_IER)) begin
          ier_reg[c] <= wr_value(c, uart_hostport_pkg::IDX_IER) &
                        uart_hostport_pkg::IER_USED_MASK;
        end
      end
    end
  end

  // line control is plain storage in this block
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      for (int c = 0; c < NCH; c++) begin
        lcr_reg[c] <= uart_hostport_pkg::LCR_RESET;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_hit(c, uart_hostport_pkg::IDX_LCR)) begin
          lcr_reg[c] <= wr_value(c, uart_hostport_pkg::IDX_LCR);
        end
      end
    end
  end

  // bit 3 is the channel pin drive enable
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      for (int c = 0; c < NCH; c++) begin
        mcr_reg[c] <= uart_hostport_pkg::MCR_RESET;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_hit(c, uart_hostport_pkg::IDX_MCR)) begin
          mcr_reg[c] <= wr_value(c, uart_hostport_pkg::IDX_MCR);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      for (int c = 0; c < NCH; c++) begin
        spr_reg[c] <= uart_hostport_pkg::SPR_RESET;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_hit(c, uart_hostport_pkg::IDX_SPR)) begin
          spr_reg[c] <= wr_value(c, uart_hostport_pkg::IDX_SPR);
        end
      end
    end
  end

  // select pin has no say in combined mode
  assign sel_eff = irq_drive_select_in & ~combined_mode_in;

  for (genvar g = 0; g < NCH; g++) begin : g_chan
    chan_irq_gate u_gate (
      .sys_clk_in       (sys_clk_in),
      .nrst_in          (nrst_in),
      .cond_in          (irq_cond_in[g]),
      .ier_in           (ier_reg[g]),
      .mcr_oe_in        (mcr_reg[g][uart_hostport_pkg::MCR_IRQ_OE_BIT]),
      .drive_select_in  (sel_eff),
      .combined_mode_in (combined_mode_in),
      .pending_out      (pending[g]),
      .irq_out          (irq_out[g]),
      .irq_oe_out       (irq_oe_out[g])
    );
  end

  // open drain: pulled low only, external pull-up makes the high level
  // pending is combinational, so the pull follows its cause one edge late
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      irq_shared_n_out    <= 1'b0;
      irq_shared_n_oe_out <= 1'b0;
    end else begin
      irq_shared_n_out    <= 1'b0;
      irq_shared_n_oe_out <= combined_mode_in & (|pending);
    end
  end

endmodule : quad_uart_host_strobe_irq_ctrl

/* File: sim/quad_uart_host_strobe_irq_ctrl_checker.sv */
/*
  concurrent checks on the strobe port and interrupt pins of the top module.
  assumes one clock domain and the synchronous active-low reset.
*/
module quad_uart_host_strobe_irq_ctrl_checker #(
  parameter int unsigned NCH = 4
) (
  input wire logic                                       sys_clk_in,
  input wire logic                                       nrst_in,
  input wire uart_hostport_pkg::host_ctl_type            host_ctl_in,
  input wire logic                                       combined_mode_in,
  input wire logic                                       irq_drive_select_in,
  input wire uart_hostport_pkg::irq_cond_type [NCH-1:0]  irq_cond_in,
  input wire logic [7:0]                                 host_data_out,
  input wire logic                                       host_data_oe_out,
  input wire logic [NCH-1:0]                             irq_out,
  input wire logic [NCH-1:0]                             irq_oe_out,
  input wire logic                                       irq_shared_n_out,
  input wire logic                                       irq_shared_n_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NCH-1:0] any_cond;
  logic           rd_prev;
  logic           rd_on;
  logic           rd_fall;
  // enables are internal, so only "some condition present" is visible here
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      any_cond[i] = |irq_cond_in[i];
    end
  end
  assign rd_on   = !host_ctl_in.rd_n && host_ctl_in.cs_n != '1 && !combined_mode_in;
  assign rd_fall = rd_on && rd_prev;
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) rd_prev <= 1'b1;
    else rd_prev <= host_ctl_in.rd_n;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  AST_SEL_DRIVE: assert property (irq_drive_select_in && !combined_mode_in |=> irq_oe_out == '1)
    else $error("channel pins not driven with select high");
  AST_COMB_OFF: assert property (combined_mode_in |=> irq_oe_out == '0)
    else $error("channel pin driven in combined mode");
  AST_OUT_NEEDS_OE: assert property (!$past(combined_mode_in) |-> (irq_out & ~irq_oe_out) == '0)
    else $error("channel interrupt asserted while not driven");
  AST_NO_COND: assert property ((irq_out & ~$past(any_cond)) == '0)
    else $error("channel interrupt without a condition");
  AST_SHARED_LOW: assert property (irq_shared_n_out == 1'b0)
    else $error("shared request value not low");
  AST_SHARED_IDLE: assert property (combined_mode_in && any_cond == '0 |=> !irq_shared_n_oe_out)
    else $error("shared request pulled with nothing pending");
  AST_SHARED_CAUSE: assert property (irq_shared_n_oe_out |-> $past(combined_mode_in))
    else $error("shared request pulled outside combined mode");
  AST_RD_OE: assert property (rd_on |=> host_data_oe_out)
    else $error("data bus not driven during read");
  AST_OE_CAUSE: assert property (host_data_oe_out |-> $past(rd_on))
    else $error("data bus driven without a selected read");
  AST_DATA_HELD: assert property (!$stable(host_data_out) |-> $past(rd_fall))
    else $error("read data changed without a read fall");
endmodule : quad_uart_host_strobe_irq_ctrl_checker

bind quad_uart_host_strobe_irq_ctrl quad_uart_host_strobe_irq_ctrl_checker #(.NCH(NCH)) chk (
  .sys_clk_in, .nrst_in, .host_ctl_in, .combined_mode_in, .irq_drive_select_in,
  .irq_cond_in, .host_data_out, .host_data_oe_out, .irq_out, .irq_oe_out,
  .irq_shared_n_out, .irq_shared_n_oe_out);

/* File: sim/host_cpu_model.sv */
/*
  host cpu on the split strobe bus: chip selects, index, strobes, data.
  assumes the device answers a read within the hold chosen per transfer.
*/
module host_cpu_model (
  input  wire logic                       sys_clk_in,
  input  wire logic [7:0]                 rd_data_in,
  output uart_hostport_pkg::host_ctl_type ctl_out,
  output logic [7:0]                      wr_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ctl_out     = '1;
    wr_data_out = 8'h00;
  end
  // hold of 1 or more edges: read data shows one edge after the fall
  task automatic xfer(input logic wr, input logic [1:0] ch, input logic [2:0] idx,
                      input logic [7:0] wd, input int hold, output logic [7:0] rd);
    @(posedge sys_clk_in);
    ctl_out.cs_n <= ~(4'h1 << ch);
    ctl_out.addr <= idx;
    wr_data_out  <= wd;
    @(posedge sys_clk_in);
    if (wr) ctl_out.wr_n <= 1'b0;
    else ctl_out.rd_n <= 1'b0;
    repeat (hold) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rd = rd_data_in;
    @(posedge sys_clk_in);
    ctl_out.rd_n <= 1'b1;
    ctl_out.wr_n <= 1'b1;
    @(posedge sys_clk_in);
    ctl_out.cs_n <= 4'hF;
    wr_data_out  <= ~wd; // released bus never shows the stale value
  endtask : xfer
endmodule : host_cpu_model

/* File: sim/quad_uart_host_strobe_irq_ctrl_bench.sv */
/*
  bench for the quad uart host port: apb and strobe tasks with compares.
  assumes the package, design, checker and host model are compiled first.
*/
module quad_uart_host_strobe_irq_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  uart_hostport_pkg::host_ctl_type       host_ctl;
  uart_hostport_pkg::irq_cond_type [3:0] cond;
  logic        sys_clk_in, nrst_in, psel, penable, pwrite, pready, pslverr, e;
  logic        irq_drive_select_in, combined_mode_in, hd_oe, sh_n, sh_oe;
  logic [7:0]  hd_in, hd_out, paddr, v;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  irq, irq_oe;
  int          errors = 0;
  int          checked = 0;
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  host_cpu_model cpu (.sys_clk_in, .rd_data_in(hd_out), .ctl_out(host_ctl), .wr_data_out(hd_in));
  quad_uart_host_strobe_irq_ctrl uut (.sys_clk_in, .nrst_in, .host_ctl_in(host_ctl),
    .host_data_in(hd_in), .host_data_out(hd_out), .host_data_oe_out(hd_oe),
    .irq_drive_select_in, .combined_mode_in, .irq_cond_in(cond), .irq_out(irq),
    .irq_oe_out(irq_oe), .irq_shared_n_out(sh_n), .irq_shared_n_oe_out(sh_oe),
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do @(posedge sys_clk_in); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [7:0] ra(input int ch, input int idx);
    return 8'((ch * 8 + idx) * 4);
  endfunction : ra
  // outputs are registered: let two edges land, look at the falling edge
  task automatic settle;
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
  endtask : settle
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    errors++;
    tally_and_finish();
  end
  initial begin
    nrst_in = 1'b0;
    {psel, penable, pwrite, irq_drive_select_in, combined_mode_in} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cond = '0;
    repeat (3) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    apb(1'b1, 8'h84, 32'h0000005A);
    check("unmapped error", 32'(e), 32'h1);
    for (int c = 0; c < 4; c++) cpu.xfer(1'b1, 2'(c), 3'h7, 8'hA0 + 8'(c), 2, v);
    for (int c = 0; c < 4; c++) begin
      cpu.xfer(1'b0, 2'(c), 3'h7, 8'h00, 2 + c, v);
      check("strobe scratch", 32'(v), 32'hA0 + c);
      apb(1'b0, ra(c, 7), 32'h0);
      check("apb scratch", r, 32'hA0 + c);
    end
    $display("test strobe done");
    combined_mode_in <= 1'b1;
    irq_drive_select_in <= 1'b1;
    cpu.xfer(1'b1, 2'h0, 3'h7, 8'h55, 2, v);
    apb(1'b0, ra(0, 7), 32'h0);
    check("combined write", r, 32'hA0);
    apb(1'b1, ra(2, 1), 32'h01);
    cond[2] <= 4'h1;
    settle();
    check("combined pins", 32'(irq_oe), 32'h0);
    check("shared oe", 32'(sh_oe), 32'h1);
    check("shared value", 32'(sh_n), 32'h0);
    apb(1'b0, uart_hostport_pkg::APB_STATUS_ADDR, 32'h0);
    check("combined status", r, 32'h0000_1040);
    cond[2] <= 4'h0;
    combined_mode_in <= 1'b0;
    irq_drive_select_in <= 1'b0;
    $display("test combined done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ra(k, 1), 32'(1 << k));
      cond[k] <= 4'(1 << k);
    end
    settle();
    check("pins idle", 32'(irq_oe), 32'h0);
    for (int k = 0; k < 4; k++) cpu.xfer(1'b1, 2'(k), 3'h4, 8'h08, 3, v);
    settle();
    check("pins driven", 32'(irq_oe), 32'hF);
    check("irq all", 32'(irq), 32'hF);
    apb(1'b1, ra(0, 1), 32'h02);
    settle();
    check("irq disabled", 32'(irq), 32'hE);
    for (int k = 0; k < 4; k++) apb(1'b1, ra(k, 4), 32'h0);
    irq_drive_select_in <= 1'b1;
    settle();
    check("select drive", 32'(irq_oe), 32'hF);
    check("select irq", 32'(irq), 32'hE);
    check("shared idle", 32'(sh_oe), 32'h0);
    apb(1'b0, uart_hostport_pkg::APB_STATUS_ADDR, 32'h0);
    check("select status", r, 32'h0000_0FE1);
    apb(1'b0, ra(2, 2), 32'h0);
    check("source code", r, 32'(uart_hostport_pkg::ISR_RX_ERR));
    irq_drive_select_in <= 1'b0;
    settle();
    check("bit off", 32'(irq_oe), 32'h0);
    $display("test irq done");
    tally_and_finish();
  end
endmodule : quad_uart_host_strobe_irq_ctrl_bench
